// file: core/supply_voltage_monitor.sv
// supply voltage monitor: periodic measurement, low-supply flag, gain correction
module supply_voltage_monitor
    import supply_mon_pkg::*;
#(
    parameter int MEAS_PERIOD = supply_mon_pkg::MEAS_PERIOD_CYC, // cycles per measurement
    parameter int SW = supply_mon_pkg::STRAIN_W // strain result width
) (
    input wire logic i_clk, // core clock, 100 mhz
    input wire logic i_rst_b, // async reset, active low
    input wire logic [supply_mon_pkg::ADDR_W-1:0] i_addr, // register address
    input wire logic [supply_mon_pkg::DATA_W-1:0] i_wdata, // register write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [supply_mon_pkg::DATA_W-1:0] o_rdata, // read data, cycle after strobe
    output logic o_meas_start, // pulse: start supply conversion
    input wire logic i_meas_valid, // pulse: conversion finished
    input wire logic [supply_mon_pkg::CODE_W-1:0] i_meas_code, // conversion result
    output logic o_ram_we, // pulse: write supply code to ram
    output logic [supply_mon_pkg::RAM_AW-1:0] o_ram_addr, // ram word address
    output logic [supply_mon_pkg::RAM_W-1:0] o_ram_wdata, // ram word data
    output logic o_low_supply_flag, // supply below chosen level
    output logic o_eeprom_wr_inhibit, // automatic eeprom writes blocked
    input wire logic i_strain_valid, // pulse: raw strain result
    input wire logic signed [SW-1:0] i_strain_result, // raw strain result
    output logic o_strain_valid, // pulse: corrected strain result
    output logic signed [SW-1:0] o_strain_result, // corrected strain result
    output logic o_strain_busy, // correction divide running
    output logic o_irq // level: enabled event pending
);
    import supply_mon_pkg::*;

    localparam int NUM_W = SW + CORR_SHIFT; // dividend width
    localparam int PROD_W = CODE_W + COEFF_W + 1; // signed product width

    // supply code below a limit code, used for flag and inhibit
    function automatic logic below_code(input logic [CODE_W-1:0] code, input logic [CODE_W:0] limit);
        below_code = {1'b0, code} < limit;
    endfunction : below_code

    // reset release through two flops
    logic rst_s1_q; // first stage, read only by the second
    logic rst_n; // synchronised reset for the design

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // software control state
    logic [LOW_SEL_W-1:0] low_sel_q; // threshold select
    logic corr_en_q; // supply_gain_corr_enable
    logic [COEFF_W-1:0] coeff_q; // supply_gain_corr_coeff
    logic [IRQ_W-1:0] irq_en_q; // event enables
    logic [IRQ_W-1:0] irq_stat_q; // sticky events

    // measurement results
    logic [CODE_W-1:0] supply_code_q; // last stored supply code
    logic low_q; // low_supply_flag
    logic inhibit_q; // eeprom write inhibit
    logic seen_q; // at least one measurement stored

    // register bus decode
    wire wr_ctrl = i_wr && i_addr == REG_CTRL;
    wire wr_irq_en = i_wr && i_addr == REG_IRQ_EN;
    wire wr_irq_clr = i_wr && i_addr == REG_IRQ_CLR;

    // control registers written by software
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_sel_q <= CTRL_SEL_RST;
            corr_en_q <= 1'b0;
            coeff_q <= CTRL_COEFF_RST;
            irq_en_q <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                low_sel_q <= i_wdata[CTRL_SEL_LSB +: LOW_SEL_W];
                corr_en_q <= i_wdata[CTRL_CORR_EN_BIT];
                coeff_q <= i_wdata[CTRL_COEFF_LSB +: COEFF_W];
            end
            if (wr_irq_en)
            begin
                irq_en_q <= i_wdata[IRQ_W-1:0];
            end
        end
    end

    // measurement repetition timer
    logic [31:0] tmr_q; // cycles into the current period
    wire tmr_wrap = tmr_q == 32'(MEAS_PERIOD - 1);

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            tmr_q <= 32'h0;
        else
            tmr_q <= tmr_wrap ? 32'h0 : tmr_q + 32'h1;
    end

    // measurement sequencer
    typedef enum logic [0:0] {MEAS_IDLE, MEAS_WAIT} meas_state_t;
    meas_state_t meas_q; // sequencer state
    meas_state_t meas_d; // next state
    logic start_q; // start pulse register

    // conversion taken only while one is outstanding
    wire meas_take = meas_q == MEAS_WAIT && i_meas_valid;

    always_comb
    begin
        meas_d = meas_q;
        case (meas_q)
            MEAS_IDLE:
                if (tmr_wrap)
                    meas_d = MEAS_WAIT;
            MEAS_WAIT:
                if (i_meas_valid)
                    meas_d = MEAS_IDLE;
            default:
                meas_d = MEAS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_q <= MEAS_IDLE;
            start_q <= 1'b0;
        end
        else
        begin
            meas_q <= meas_d;
            start_q <= meas_q == MEAS_IDLE && tmr_wrap;
        end
    end

    // threshold codes: level 2.2 v + 0.1 v * sel equals code 8 + 4 * sel
    wire [CODE_W:0] low_limit = (CODE_W+1)'(LOW_BASE_CODE) + (CODE_W+1)'(low_sel_q) * (CODE_W+1)'(LOW_STEP_CODE);
    wire low_d = below_code(i_meas_code, low_limit);
    wire inhibit_d = below_code(i_meas_code, (CODE_W+1)'(EEPROM_MIN_CODE));

    // code, flag and inhibit move in the same cycle
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            supply_code_q <= '0;
            low_q <= 1'b0;
            inhibit_q <= 1'b0;
            seen_q <= 1'b0;
        end
        else if (meas_take)
        begin
            supply_code_q <= i_meas_code;
            low_q <= low_d;
            inhibit_q <= inhibit_d;
            seen_q <= 1'b1;
        end
    end

    // ram write port for the stored code
    logic ram_we_q; // write pulse
    logic [RAM_W-1:0] ram_wdata_q; // word written

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ram_we_q <= 1'b0;
            ram_wdata_q <= '0;
        end
        else
        begin
            ram_we_q <= meas_take;
            if (meas_take)
                ram_wdata_q <= RAM_W'(i_meas_code);
        end
    end

    // gain correction: q = hb * 2^21 / (2^21 + code * coeff)
    gain_div_if #(.NUM_W(NUM_W), .DEN_W(DEN_W)) div_bus ();

    gain_divider #(.NUM_W(NUM_W), .DEN_W(DEN_W)) u_div (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .bus(div_bus)
    );

    // divisor stays positive: |code * coeff| is far below 2^21
    wire signed [PROD_W-1:0] corr_prod = $signed({1'b0, supply_code_q}) * $signed(coeff_q);
    wire signed [DEN_W-1:0] corr_den = (DEN_W)'(1 << CORR_SHIFT) + (DEN_W)'(corr_prod);
    wire strain_neg = i_strain_result[SW-1];
    wire [SW-1:0] strain_mag = strain_neg ? SW'(-i_strain_result) : SW'(i_strain_result);
    wire [SW-1:0] mag_max = {1'b0, {(SW-1){1'b1}}}; // saturation bound

    // quotient clamped to the result range
    wire quot_big = |div_bus.quot[NUM_W-1:SW-1];
    wire [SW-1:0] quot_sat = quot_big ? mag_max : div_bus.quot[SW-1:0];

    // strain path: take, divide or pass, deliver
    logic busy_q; // divide outstanding
    logic neg_q; // sign of the raw result
    logic sv_q; // corrected result strobe
    logic signed [SW-1:0] sres_q; // corrected result
    logic div_start_q; // divider request
    logic [NUM_W-1:0] div_num_q; // latched dividend
    logic [DEN_W-1:0] div_den_q; // latched divisor

    wire strain_take = i_strain_valid && !busy_q;
    wire strain_drop = i_strain_valid && busy_q;

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            neg_q <= 1'b0;
            sv_q <= 1'b0;
            sres_q <= '0;
            div_start_q <= 1'b0;
            div_num_q <= '0;
            div_den_q <= '0;
        end
        else
        begin
            div_start_q <= strain_take && corr_en_q;
            sv_q <= (strain_take && !corr_en_q) || div_bus.done;
            if (strain_take && corr_en_q)
            begin
                busy_q <= 1'b1;
                neg_q <= strain_neg;
                div_num_q <= {strain_mag, {CORR_SHIFT{1'b0}}};
                div_den_q <= corr_den;
            end
            else if (strain_take)
                sres_q <= i_strain_result;
            else if (div_bus.done)
            begin
                busy_q <= 1'b0;
                sres_q <= neg_q ? -$signed(quot_sat) : $signed(quot_sat);
            end
        end
    end

    assign div_bus.start = div_start_q;
    assign div_bus.numer = div_num_q;
    assign div_bus.denom = div_den_q;

    // events; a set wins over a clear in the same cycle
    logic [IRQ_W-1:0] ev; // event pulses this cycle
    assign ev[IRQ_MEAS_BIT] = meas_take;
    assign ev[IRQ_LOW_BIT] = meas_take && low_d && !low_q;
    assign ev[IRQ_DROP_BIT] = strain_drop;
    wire [IRQ_W-1:0] clr = wr_irq_clr ? i_wdata[IRQ_W-1:0] : '0;
    logic irq_q; // interrupt output register

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~clr) | ev;
            irq_q <= |(((irq_stat_q & ~clr) | ev) & irq_en_q);
        end
    end

    // read mux
    logic [DATA_W-1:0] rd_mux; // selected register
    always_comb
    begin
        rd_mux = '0;
        case (i_addr)
            REG_CTRL:
            begin
                rd_mux[CTRL_SEL_LSB +: LOW_SEL_W] = low_sel_q;
                rd_mux[CTRL_CORR_EN_BIT] = corr_en_q;
                rd_mux[CTRL_COEFF_LSB +: COEFF_W] = coeff_q;
            end
            REG_STATUS:
            begin
                rd_mux[STAT_CODE_LSB +: CODE_W] = supply_code_q;
                rd_mux[STAT_LOW_BIT] = low_q;
                rd_mux[STAT_INHIBIT_BIT] = inhibit_q;
                rd_mux[STAT_SEEN_BIT] = seen_q;
                rd_mux[STAT_BUSY_BIT] = busy_q;
            end
            REG_IRQ_STAT:
                rd_mux[IRQ_W-1:0] = irq_stat_q;
            REG_IRQ_EN:
                rd_mux[IRQ_W-1:0] = irq_en_q;
            default:
                rd_mux = '0; // unmapped and write-only read zero
        endcase
    end

    // read data register, stands one cycle
    logic [DATA_W-1:0] rdata_q; // read answer
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= '0;
        else
            rdata_q <= i_rd ? rd_mux : '0;
    end

    // outputs, each from a flop except o_ram_addr, which is the constant SUPPLY_RAM_ADDR
    assign o_rdata = rdata_q;
    assign o_meas_start = start_q;
    assign o_ram_we = ram_we_q;
    assign o_ram_addr = SUPPLY_RAM_ADDR;
    assign o_ram_wdata = ram_wdata_q;
    assign o_low_supply_flag = low_q;
    assign o_eeprom_wr_inhibit = inhibit_q;
    assign o_strain_valid = sv_q;
    assign o_strain_result = sres_q;
    assign o_strain_busy = busy_q;
    assign o_irq = irq_q;

    // parameters the logic cannot serve
    if (MEAS_PERIOD < 2)
        $error("supply_voltage_monitor: MEAS_PERIOD too small");
    if (SW < 8 || SW > 32)
        $error("supply_voltage_monitor: SW out of range");

endmodule : supply_voltage_monitor

// file: core/supply_mon_pkg.sv
// constants, register map and field layout shared by the supply monitor files
package supply_mon_pkg;

    // clock and measurement timing
    localparam int CLK_HZ = 100_000_000; // core clock rate
    localparam int MEAS_RATE_HZ = 40; // supply measurements per second
    localparam int MEAS_PERIOD_CYC = CLK_HZ / MEAS_RATE_HZ; // cycles between measurement starts

    // widths
    localparam int ADDR_W = 8; // register bus address width
    localparam int DATA_W = 32; // register bus data width
    localparam int CODE_W = 8; // supply code width
    localparam int RAM_AW = 8; // internal ram address width
    localparam int RAM_W = 24; // internal ram word width
    localparam int STRAIN_W = 24; // strain result width
    localparam int COEFF_W = 8; // signed gain coefficient width
    localparam int LOW_SEL_W = 3; // low-supply threshold select width
    localparam int CORR_SHIFT = 21; // coefficient scale, 2^21
    localparam int DEN_W = 23; // divisor width, holds 2^21 plus correction

    // internal ram word receiving each supply code (decimal 249)
    localparam logic [RAM_AW-1:0] SUPPLY_RAM_ADDR = 8'hf9;

    // supply code thresholds: v = 2.0 + 0.025 * code
    localparam int LOW_BASE_CODE = 8; // 2.2 v at select 0
    localparam int LOW_STEP_CODE = 4; // 0.1 v per select step
    localparam int EEPROM_MIN_CODE = 16; // 2.4 v eeprom write floor

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00; // threshold, correction control
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04; // code, flags, busy
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08; // sticky events, read only
    localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h0c; // event enables
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h10; // write one to clear, write only

    // control register fields
    localparam int CTRL_SEL_LSB = 0; // low-supply select [2:0]
    localparam int CTRL_CORR_EN_BIT = 3; // correction enable
    localparam int CTRL_COEFF_LSB = 8; // coefficient [15:8]
    localparam logic [LOW_SEL_W-1:0] CTRL_SEL_RST = 3'h0; // select after reset
    localparam logic [COEFF_W-1:0] CTRL_COEFF_RST = 8'h00; // coefficient after reset

    // status register fields
    localparam int STAT_CODE_LSB = 0; // supply code [7:0]
    localparam int STAT_LOW_BIT = 8; // low-supply flag
    localparam int STAT_INHIBIT_BIT = 9; // eeprom write inhibit
    localparam int STAT_SEEN_BIT = 10; // a measurement has completed
    localparam int STAT_BUSY_BIT = 11; // correction divide running

    // interrupt event bits
    localparam int IRQ_W = 3; // number of events
    localparam int IRQ_MEAS_BIT = 0; // measurement stored
    localparam int IRQ_LOW_BIT = 1; // supply dropped below threshold
    localparam int IRQ_DROP_BIT = 2; // strain result refused while busy

endpackage : supply_mon_pkg

// file: core/gain_div_if.sv
// request and answer wires between the monitor and its correction divider
interface gain_div_if #(
    parameter int NUM_W = 45,
    parameter int DEN_W = 23
);
    logic start; // one-cycle request
    logic [NUM_W-1:0] numer; // unsigned dividend
    logic [DEN_W-1:0] denom; // unsigned divisor, nonzero
    logic done; // one-cycle answer
    logic [NUM_W-1:0] quot; // quotient, valid with done

    modport master (output start, output numer, output denom, input done, input quot);
    modport slave (input start, input numer, input denom, output done, output quot);
endinterface : gain_div_if

// file: core/gain_divider.sv
// bit-serial restoring divider for the supply gain correction
module gain_divider #(
    parameter int NUM_W = 45,
    parameter int DEN_W = 23
) (
    input wire logic i_clk, // core clock
    input wire logic i_rst_n, // synchronised reset, active low
    gain_div_if.slave bus // request and answer
);
    // iteration state
    logic busy_q; // division running
    logic [7:0] cnt_q; // bits still to resolve
    logic [NUM_W-1:0] num_q; // dividend, shifted out msb first
    logic [NUM_W-1:0] quot_q; // quotient being built
    logic [DEN_W:0] rem_q; // partial remainder
    logic [DEN_W-1:0] den_q; // latched divisor
    logic done_q; // answer strobe

    // one restoring step
    wire [DEN_W:0] rem_sh = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};
    wire fits = rem_sh >= {1'b0, den_q};
    wire [DEN_W:0] rem_nx = fits ? rem_sh - {1'b0, den_q} : rem_sh;

    // start latches operands, then one quotient bit per cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            num_q <= '0;
            quot_q <= '0;
            rem_q <= '0;
            den_q <= '0;
            done_q <= 1'b0;
        end
        else if (bus.start && !busy_q)
        begin
            busy_q <= 1'b1;
            cnt_q <= 8'(NUM_W);
            num_q <= bus.numer;
            den_q <= bus.denom;
            rem_q <= '0;
            quot_q <= '0;
            done_q <= 1'b0;
        end
        else if (busy_q)
        begin
            rem_q <= rem_nx;
            num_q <= {num_q[NUM_W-2:0], 1'b0};
            quot_q <= {quot_q[NUM_W-2:0], fits};
            cnt_q <= cnt_q - 8'h01;
            busy_q <= cnt_q != 8'h01;
            done_q <= cnt_q == 8'h01;
        end
        else
        begin
            done_q <= 1'b0;
        end
    end

    assign bus.done = done_q;
    assign bus.quot = quot_q;

    // the step counter is eight bits wide
    if (NUM_W > 255 || NUM_W < 2)
        $error("gain_divider: NUM_W out of range");

endmodule : gain_divider

// file: bench/supply_voltage_monitor_properties.sv
// port-level assertions for the supply voltage monitor
module supply_voltage_monitor_properties
    import supply_mon_pkg::*;
#(
    parameter int MEAS_PERIOD = supply_mon_pkg::MEAS_PERIOD_CYC, // cycles per measurement
    parameter int SW = supply_mon_pkg::STRAIN_W // strain width
) (
    input wire logic i_clk, // core clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic [supply_mon_pkg::ADDR_W-1:0] i_addr, // register address
    input wire logic [supply_mon_pkg::DATA_W-1:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic o_meas_start, // conversion request
    input wire logic i_meas_valid, // conversion done
    input wire logic [supply_mon_pkg::CODE_W-1:0] i_meas_code, // conversion code
    input wire logic o_ram_we, // ram write pulse
    input wire logic [supply_mon_pkg::RAM_AW-1:0] o_ram_addr, // ram address
    input wire logic [supply_mon_pkg::RAM_W-1:0] o_ram_wdata, // ram data
    input wire logic o_low_supply_flag, // low supply
    input wire logic o_eeprom_wr_inhibit, // eeprom writes blocked
    input wire logic i_strain_valid, // raw strain pulse
    input wire logic signed [SW-1:0] i_strain_result, // raw strain
    input wire logic o_strain_valid, // corrected pulse
    input wire logic signed [SW-1:0] o_strain_result, // corrected strain
    input wire logic o_strain_busy // divide running
);
    logic [2:0] sel_q; // low select as last written
    logic en_q; // correction enable as last written
    int since_q; // cycles since last start
    logic seen_q; // a start has been seen

    // shadow of the control fields and the start spacing
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sel_q <= 3'h0;
            en_q <= 1'b0;
            since_q <= 0;
            seen_q <= 1'b0;
        end
        else
        begin
            if (i_wr && i_addr == REG_CTRL)
            begin
                sel_q <= i_wdata[2:0];
                en_q <= i_wdata[3];
            end
            since_q <= o_meas_start ? 0 : since_q + 1;
            seen_q <= seen_q | o_meas_start;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    ram_addr_fixed_a:
        assert property (o_ram_addr == SUPPLY_RAM_ADDR) else $error("ram address not fixed");
    ram_write_code_a:
        assert property (o_ram_we |-> $past(i_meas_valid) && o_ram_wdata == {16'h0, $past(i_meas_code)})
        else $error("ram write without matching code");
    low_flag_level_a:
        assert property (o_ram_we |-> o_low_supply_flag == (o_ram_wdata[7:0] < 8 + 4 * $past(sel_q)))
        else $error("low flag wrong for code");
    inhibit_level_a:
        assert property (o_ram_we |-> o_eeprom_wr_inhibit == (o_ram_wdata[7:0] < 16))
        else $error("inhibit wrong for code");
    results_hold_a:
        assert property (!o_ram_we |-> $stable({o_low_supply_flag, o_eeprom_wr_inhibit, o_ram_wdata}))
        else $error("result changed between measurements");
    start_pulse_a:
        assert property (o_meas_start |=> !o_meas_start) else $error("start longer than one cycle");
    start_period_a:
        assert property (o_meas_start && seen_q |-> since_q % MEAS_PERIOD == MEAS_PERIOD - 1)
        else $error("start spacing wrong");
    strain_bypass_a:
        assert property (i_strain_valid && !o_strain_busy && !en_q |=>
            o_strain_valid && o_strain_result == $past(i_strain_result))
        else $error("bypass result wrong");
    strain_latency_a:
        assert property (i_strain_valid && !o_strain_busy && en_q |-> ##1 o_strain_busy [*8] ##40 o_strain_valid)
        else $error("corrected result late");
endmodule : supply_voltage_monitor_properties

bind supply_voltage_monitor supply_voltage_monitor_properties #(.MEAS_PERIOD(MEAS_PERIOD), .SW(SW)) u_props (
    .i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .o_meas_start, .i_meas_valid, .i_meas_code,
    .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_low_supply_flag, .o_eeprom_wr_inhibit,
    .i_strain_valid, .i_strain_result, .o_strain_valid, .o_strain_result, .o_strain_busy);

// file: bench/supply_voltage_monitor_tb.sv
// self-checking bench for the supply voltage monitor
module supply_voltage_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import supply_mon_pkg::*;

    localparam int MP = 50; // shortened measurement period
    logic i_clk = 1'b0; // core clock
    logic i_rst_b = 1'b0; // reset, active low
    logic [7:0] i_addr = 8'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_meas_valid = 1'b0;
    logic [7:0] i_meas_code = 8'h0;
    logic i_strain_valid = 1'b0;
    logic signed [23:0] i_strain_result = 24'h0;
    logic [31:0] o_rdata;
    logic o_meas_start, o_ram_we, o_low_supply_flag, o_eeprom_wr_inhibit;
    logic o_strain_valid, o_strain_busy, o_irq;
    logic [7:0] o_ram_addr;
    logic [23:0] o_ram_wdata;
    logic signed [23:0] o_strain_result;
    logic [63:0] rq[$]; // mask and expected read data
    logic [25:0] mq[$]; // expected flag, inhibit, ram word
    logic signed [23:0] sq[$]; // expected corrected strain
    logic [63:0] re; // read note in hand
    int bad_count = 0;
    int n_tests = 0;
    logic rd_d = 1'b0; // read answer due
    logic start_seen = 1'b0; // unanswered conversion request
    logic [7:0] code_q; // last stored code
    logic [2:0] sel; // threshold in force
    logic signed [7:0] k; // gain coefficient
    logic signed [23:0] hb; // raw strain

    supply_voltage_monitor #(.MEAS_PERIOD(MP)) supply_voltage_monitor_inst (.i_clk, .i_rst_b, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .o_meas_start, .i_meas_valid, .i_meas_code, .o_ram_we,
        .o_ram_addr, .o_ram_wdata, .o_low_supply_flag, .o_eeprom_wr_inhibit, .i_strain_valid,
        .i_strain_result, .o_strain_valid, .o_strain_result, .o_strain_busy, .o_irq);

    always #5 i_clk = ~i_clk;

    // automatic: the watcher and the main sequence may both call it at one edge
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task hang;
        bad_count++;
        $display("mismatch at %0t: wait ran out", $time);
        finish_test();
    endtask : hang

    // output watcher: takes the oldest note whenever a result shows
    always @(posedge i_clk)
    begin
        if (rd_d)
        begin
            re = rq.pop_front();
            check(o_rdata & re[63:32], re[31:0] & re[63:32]);
        end
        rd_d <= i_rd;
        if (o_ram_we === 1'b1)
        begin
            check({o_low_supply_flag, o_eeprom_wr_inhibit, o_ram_wdata}, mq.pop_front());
            check(o_ram_addr, SUPPLY_RAM_ADDR);
        end
        if (o_strain_valid === 1'b1)
            check(o_strain_result, sq.pop_front());
        if (o_meas_start === 1'b1)
            start_seen <= 1'b1;
    end

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        rq.push_back({m, e});
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask : rd

    // answer the pending conversion request with a code
    task meas(input logic [7:0] c);
        int n;
        logic f;
        logic h;
        n = 0;
        f = c < 8 + 4 * sel;
        h = c < 16;
        while (start_seen !== 1'b1 && n < 3 * MP)
        begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 3 * MP)
            hang();
        start_seen = 1'b0;
        @(posedge i_clk);
        i_meas_valid <= 1'b1;
        i_meas_code <= c;
        mq.push_back({f, h, 16'h0, c});
        @(posedge i_clk);
        i_meas_valid <= 1'b0;
        i_meas_code <= ~c;
        code_q = c;
        rd(REG_STATUS, {20'h0, 2'b01, h, f, c}, 32'hffffffff);
    endtask : meas

    task idle;
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_strain_busy !== 1'b0 && n < 100);
        if (n >= 100)
            hang();
    endtask : idle

    task strain(input logic signed [23:0] v, input logic signed [23:0] e);
        idle();
        i_strain_valid <= 1'b1;
        i_strain_result <= v;
        sq.push_back(e);
        @(posedge i_clk);
        i_strain_valid <= 1'b0;
        i_strain_result <= ~v;
    endtask : strain

    function automatic logic signed [23:0] corr(input logic signed [23:0] v, input logic [7:0] c,
        input logic signed [7:0] g);
        longint a;
        longint q;
        a = (v < 0) ? -longint'(v) : longint'(v);
        q = (a << 21) / ((longint'(1) << 21) + longint'(c) * longint'(g));
        if (q > longint'(24'h7fffff))
            q = longint'(24'h7fffff);
        return (v < 0) ? 24'(-q) : 24'(q);
    endfunction : corr

    // main sequence
    initial
    begin
        void'($urandom(95003));
        sel = 3'h0;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd(REG_CTRL, 32'h0, 32'hffffffff);
        rd(REG_STATUS, 32'h0, 32'hffffffff);
        rd(8'h40, 32'h0, 32'hffffffff);
        for (int s = 0; s < 8; s++)
        begin
            sel = 3'(s);
            wr(REG_CTRL, {29'h0, sel});
            meas(8'(7 + 4 * s));
            meas(8'(8 + 4 * s));
            meas(8'($urandom_range(255)));
        end
        wr(REG_IRQ_CLR, 32'h7);
        wr(REG_IRQ_EN, 32'h1);
        meas(8'h40);
        repeat (3) @(posedge i_clk);
        check(o_irq, 1'b1);
        rd(REG_IRQ_STAT, 32'h1, 32'h1);
        wr(REG_IRQ_CLR, 32'h1);
        repeat (2) @(posedge i_clk);
        check(o_irq, 1'b0);
        wr(REG_IRQ_EN, 32'h0);
        meas(8'h41);
        repeat (3) @(posedge i_clk);
        check(o_irq, 1'b0);
        rd(REG_IRQ_STAT, 32'h1, 32'h1);
        k = 8'($urandom);
        wr(REG_CTRL, {16'h0, k, 8'h00});
        repeat (4)
        begin
            hb = 24'($urandom);
            strain(hb, hb);
        end
        for (int j = 0; j < 3; j++)
        begin
            k = (j == 0) ? 8'h80 : (j == 1) ? 8'h7f : 8'($urandom);
            idle();
            wr(REG_CTRL, {16'h0, k, 8'h08});
            hb = (j == 0) ? 24'h800000 : 24'($urandom);
            strain(hb, corr(hb, code_q, k));
            @(posedge i_clk);
            i_strain_valid <= 1'b1;
            @(posedge i_clk);
            i_strain_valid <= 1'b0;
            rd(REG_IRQ_STAT, 32'h4, 32'h4);
            wr(REG_IRQ_CLR, 32'h4);
        end
        idle();
        repeat (3) @(posedge i_clk);
        check(32'(sq.size()), 32'h0);
        finish_test();
    end
endmodule : supply_voltage_monitor_tb
